// [sim/iowg_src_model.sv]
`timescale 1ns/10ps
// Sensor front end on a valid/ready handshake.
module iowg_src_model (
    input  wire logic          pclk,
    input  wire logic          sample_ready,
    output logic               sample_valid,
    output iowg_pkg::iowg_raw_s sample_data
);
    iowg_pkg::iowg_raw_s sent_q[$]; // Taken sets, oldest first.
    initial begin
        sample_valid = 1'b0;
        sample_data = '0;
    end
    // Holds one set until taken or 3000 cycles pass, then shows its inverse.
    task automatic send(input iowg_pkg::iowg_raw_s r);
        int n;
        sample_valid <= 1'b1;
        sample_data <= r;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (sample_ready !== 1'b1 && n < 3000);
        if (n < 3000) sent_q.push_back(r);
        sample_valid <= 1'b0;
        sample_data <= ~r;
        @(posedge pclk);
    endtask
endmodule

// [sim/iowg_width_growth_asserts.sv]
`timescale 1ns/10ps
// Register answers against the settings last written.
module iowg_width_growth_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sample_ready
);
    logic [3:0] dec_q, dec_d; // Last written decimation.
    logic [1:0] win_q, win_d; // Last written window.
    logic [5:0] gw;           // Implied gyroscope width.
    logic       wr, rd;       // Setup of a write; completed read.
    assign wr = psel && !penable && pwrite;
    assign rd = psel && penable && pready && !pwrite;
    // Next settings and implied width.
    always_comb begin
        dec_d = (wr && paddr == 8'h00) ? pwdata[3:0] : dec_q;
        win_d = (wr && paddr == 8'h04) ? pwdata[1:0] : win_q;
        gw = 6'(16 + $clog2(32'(dec_q) + 1) + 2 * 32'(win_q));
    end
    // Settings follow writes at setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_q <= 4'h0;
            win_q <= 2'h0;
        end else begin
            dec_q <= dec_d;
            win_q <= win_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_access_answer: assert property (psel && !penable |=> pready)
        else $error("no answer in the access cycle");
    a_status_width: assert property (rd && paddr == 8'h08 |->
        prdata[13:8] == gw && prdata[21:16] == gw + 6'd4) else $error("width field wrong");
    a_zero_widths: assert property (rd && paddr == 8'h08 && dec_q == 0 && win_q == 0 |->
        prdata[13:8] == 6'd16 && prdata[21:16] == 6'd20) else $error("default width wrong");
    a_dec_readback: assert property (rd && paddr == 8'h00 |-> prdata == {28'h0, dec_q})
        else $error("decimation readback wrong");
    a_word_pad: assert property (rd && paddr inside {[8'h0C:8'h3C]} |-> prdata[31:16] == 0)
        else $error("data word wider than 16 bits");
    a_ro_refuse: assert property (psel && penable && pready && pwrite && paddr >= 8'h0C
        |-> pslverr) else $error("read-only write accepted");
    a_bad_addr: assert property (psel && penable && pready && paddr > 8'h3C |->
        pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access accepted");
    a_flush_stall: assert property (wr && paddr < 8'h08 |-> ##[1:2] !sample_ready)
        else $error("input not stalled after setting write");
endmodule
bind iowg_width_growth iowg_width_growth_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_ready(sample_ready));

// [sim/iowg_width_growth_tb.sv]
`timescale 1ns/10ps
// Self-checking bench.
module iowg_width_growth_tb;
    logic                pclk, presetn, psel, penable, pwrite; // Bus controls.
    logic                pready, pslverr, sample_valid, sample_ready;
    logic [7:0]          paddr;             // Byte address.
    logic [31:0]         pwdata, prdata, rd; // Write data, read data, last read.
    logic [32:0]         got;               // Observed {pslverr, read data}.
    logic [33:0]         e, exp_q[$];       // Notes: {check, pslverr, read data}.
    iowg_pkg::iowg_raw_s sample_data, r;
    int                  errors, num_checks, seed, dec, win, i, j, k;
    longint              v[6];              // Expected lanes.

    iowg_width_growth uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .sample_data(sample_data),
        .sample_ready(sample_ready));
    iowg_src_model src (.pclk(pclk), .sample_ready(sample_ready),
        .sample_valid(sample_valid), .sample_data(sample_data));

    // 20 MHz clock.
    always #25 pclk = ~pclk;

    // Verdict and end of run.
    task automatic give_verdict();
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One mismatch; a spent wait ends the run.
    task automatic bad(input logic [32:0] x, y, input bit stop);
        errors++;
        $display("BAD t=%0t exp=%h got=%h", $time, x, y);
        if (stop) give_verdict();
    endtask

    // One APB transfer and its note.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [33:0] n_e);
        int n;
        exp_q.push_back(n_e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) bad(33'h0, 33'h1, 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Checks each finished transfer whose note sets the check bit.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            got = {pslverr, pwrite ? 32'h0 : prdata};
            if (e[33]) num_checks++;
            if (e[33] && got !== e[32:0]) bad(e[32:0], got, 1'b0);
        end
    end

    // Expected gyroscope width.
    function automatic int gw();
        return 16 + $clog2(dec + 1) + 2 * win;
    endfunction

    // Sets both filters and checks the decimation readback and the status widths.
    task automatic setf(input int d, input int w);
        dec = d;
        win = w;
        xfer(1'b1, 8'h00, 32'(d), {2'b10, 32'h0});
        xfer(1'b1, 8'h04, 32'(w), {2'b10, 32'h0});
        xfer(1'b0, 8'h00, 32'h0, {2'b10, 32'(d)});
        xfer(1'b0, 8'h08, 32'h0, {2'b10, 8'h0, 8'(gw() + 4), 8'(gw()), 8'h0});
    endtask

    // Polls until a frame is held.
    task automatic poll();
        k = 0;
        do begin
            xfer(1'b0, 8'h08, 32'h0, 34'h0);
            k++;
        end while (rd[0] !== 1'b1 && k < 300);
        if (k >= 300) bad(33'h0, 33'h2, 1'b1);
    endtask

    // Adds m times a raw set to the lanes.
    task automatic add(input iowg_pkg::iowg_raw_s s, input int m);
        for (int a = 0; a < 6; a++)
            v[a] += m * ((a < 3) ? longint'(signed'(s.gyro[a])) : longint'(signed'(s.accel[a - 3])));
    endtask

    // Checks all words and burst reads, then releases.
    task automatic words();
        logic [31:0] x[6];
        for (int a = 0; a < 6; a++) begin
            x[a] = 32'(v[a] <<< (32 - ((a < 3) ? gw() : gw() + 4)));
            xfer(1'b0, 8'(16 + 8 * a), 32'h0, {18'h2_0000, x[a][31:16]});
            xfer(1'b0, 8'(20 + 8 * a), 32'h0, {18'h2_0000, x[a][15:0]});
        end
        for (int a = 0; a < 7; a++) xfer(1'b0, 8'h0C, 32'h0, {18'h2_0000, x[a % 6][31:16]});
        xfer(1'b1, 8'h08, 32'h1, {2'b10, 32'h0});
    endtask

    // Reset, refusals, all settings, then data.
    initial begin
        {pclk, presetn, psel, penable, pwrite} = '0;
        {paddr, pwdata} = '0;
        seed = 90;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, 8'h08, 32'h0, {2'b10, 32'h0014_1000});
        xfer(1'b0, 8'h40, 32'h0, {2'b11, 32'h0});
        xfer(1'b1, 8'h10, 32'h5, {2'b11, 32'h0});
        for (i = 0; i < 64; i++) setf(i % 16, i / 16);
        // Decimation zero and one.
        for (j = 0; j < 2; j++) begin
            setf(j, 0);
            v = '{default: 0};
            for (i = 0; i <= j; i++) begin
                r = 108'({$random(seed), $random(seed), $random(seed), $random(seed)});
                src.send(r);
                add(r, 1);
            end
            poll();
            words();
        end
        // Window two on a constant: 1, 3 and 4 times it.
        setf(0, 1);
        for (i = 0; i < 3; i++) src.send(r);
        for (i = 0; i < 3; i++) begin
            poll();
            v = '{default: 0};
            add(r, (i == 0) ? 1 : i + 2);
            words();
        end
        // Fill until refused, then drain in order.
        setf(0, 0);
        src.sent_q.delete();
        fork
            for (j = 0; j < 40; j++)
                src.send(108'({$random(seed), $random(seed), $random(seed), $random(seed)}));
        join_none
        repeat (200) @(posedge pclk);
        num_checks++;
        if (src.sent_q.size() >= 40 || sample_ready !== 1'b0) bad(33'h0, 33'h3, 1'b0);
        for (i = 0; i < 40; i++) begin
            poll();
            v = '{default: 0};
            add(src.sent_q.pop_front(), 1);
            words();
        end
        give_verdict();
    end
endmodule

// [src/iowg_axis_filter.sv]
`timescale 1ns/10ps

// One channel: decimating sum followed by a two-stage moving-sum window.
module iowg_axis_filter (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        flush,
    input  wire logic                        in_valid,
    input  wire logic [iowg_pkg::DEC_W-1:0]  dec,
    input  wire logic [iowg_pkg::WIN_W-1:0]  win,
    input  wire logic signed [31:0]          in_value,
    output logic                             out_valid,
    output logic signed [31:0]               out_value
);
    logic [iowg_pkg::DEC_W-1:0] cnt_q, cnt_d;     // Samples summed so far.
    logic signed [31:0]         dsum_q, dsum_d;   // Decimation accumulator.
    logic signed [31:0]         s1_q, s1_d;       // First window running sum.
    logic signed [31:0]         s2_q, s2_d;       // Second window running sum.
    logic signed [31:0]         h1_q [iowg_pkg::HIST_DEPTH];
    logic signed [31:0]         h1_d [iowg_pkg::HIST_DEPTH];
    logic signed [31:0]         h2_q [iowg_pkg::HIST_DEPTH];
    logic signed [31:0]         h2_d [iowg_pkg::HIST_DEPTH];
    logic [2:0]                 ptr_q, ptr_d;     // History write slot.
    logic                       ov_q, ov_d;       // Output strobe.
    logic signed [31:0]         out_q, out_d;     // Output sum.
    logic signed [31:0]         dsum_n;           // Sum including this sample.
    logic [2:0]                 old_idx;          // Slot leaving the window.

    assign out_valid = ov_q;
    assign out_value = out_q;

    // Next-state logic for the whole filter chain.
    always_comb begin
        cnt_d   = cnt_q;
        dsum_d  = dsum_q;
        s1_d    = s1_q;
        s2_d    = s2_q;
        h1_d    = h1_q;
        h2_d    = h2_q;
        ptr_d   = ptr_q;
        ov_d    = 1'b0;
        out_d   = out_q;
        dsum_n  = dsum_q + in_value;
        // The slot written two-to-the-setting outputs ago drops out of each window.
        old_idx = ptr_q - 3'(4'd1 << win);
        if (flush) begin
            // A settings change restarts every accumulator from zero.
            cnt_d  = '0;
            dsum_d = '0;
            s1_d   = '0;
            s2_d   = '0;
            ptr_d  = '0;
            for (int i = 0; i < iowg_pkg::HIST_DEPTH; i++) begin
                h1_d[i] = '0;
                h2_d[i] = '0;
            end
        end else if (in_valid) begin
            // R2: sum setting plus one
            if (cnt_q == dec) begin
                cnt_d  = '0;
                dsum_d = '0;
                // R4: both stages equal length
                s1_d        = s1_q + dsum_n - h1_q[old_idx];
                h1_d[ptr_q] = dsum_n;
                s2_d        = s2_q + s1_d - h2_q[old_idx];
                h2_d[ptr_q] = s1_d;
                ptr_d       = ptr_q + 1'b1;
                ov_d        = 1'b1;
                out_d       = s2_d;
            end else begin
                // Keep summing until the decimation count is reached.
                cnt_d  = cnt_q + 1'b1;
                dsum_d = dsum_n;
            end
        end
    end

    // State registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= '0;
            dsum_q <= '0;
            s1_q   <= '0;
            s2_q   <= '0;
            ptr_q  <= '0;
            ov_q   <= 1'b0;
            out_q  <= '0;
            for (int i = 0; i < iowg_pkg::HIST_DEPTH; i++) begin
                h1_q[i] <= '0;
                h2_q[i] <= '0;
            end
        end else begin
            cnt_q  <= cnt_d;
            dsum_q <= dsum_d;
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            ptr_q  <= ptr_d;
            ov_q   <= ov_d;
            out_q  <= out_d;
            h1_q   <= h1_d;
            h2_q   <= h2_d;
        end
    end
endmodule

// [src/iowg_fifo.sv]
`timescale 1ns/10ps

// Frame queue between the filters and the register set.
module iowg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];        // Frame storage.
    logic [AW-1:0]    wr_q, wr_d;         // Write pointer.
    logic [AW-1:0]    rd_q, rd_d;         // Read pointer.
    logic [CW-1:0]    cnt_q, cnt_d;       // Number of stored frames.
    logic             push;               // Frame enters this cycle.
    logic             pop;                // Frame leaves this cycle.

    assign in_ready  = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign level     = cnt_q;

    // Pointer and count arithmetic; pointers wrap at the depth.
    always_comb begin
        push  = in_valid && in_ready;
        pop   = out_valid && out_ready;
        wr_d  = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d  = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + CW'(push) - CW'(pop);
    end

    // Pointer registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage write; the array holds data only, so it needs no reset.
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule

// [src/iowg_pkg.sv]
package iowg_pkg;

    // Common data path width of every channel after sign extension.
    localparam int DATA_W        = 32;
    // Number of output frames that can queue ahead of the register set.
    localparam int FIFO_DEPTH    = 32;
    // Number of inertial channels: three gyroscope axes, then three accelerometer axes.
    localparam int AXES          = 6;
    localparam int GYRO_AXES     = 3;
    // Raw sample widths with both filters at their zero settings.
    localparam int GYRO_BASE_W   = 16;
    localparam int ACCEL_BASE_W  = 20;
    // Setting field widths and the window history depth (two to the largest setting).
    localparam int DEC_W         = 4;
    localparam int WIN_W         = 2;
    localparam int HIST_DEPTH    = 8;
    // Level at or below which a new input sample may still be accepted (two in flight).
    localparam int ACCEPT_LEVEL  = FIFO_DEPTH - 3;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFS_DEC        = 8'h00;
    localparam logic [7:0] OFS_WIN        = 8'h04;
    localparam logic [7:0] OFS_STATUS     = 8'h08;
    localparam logic [7:0] OFS_BURST      = 8'h0C;
    localparam logic [7:0] OFS_UPPER_BASE = 8'h10;
    localparam logic [7:0] OFS_LOWER_BASE = 8'h14;
    localparam logic [7:0] OFS_AXIS_STEP  = 8'h08;

    // Reset values of the two filter settings.
    localparam logic [DEC_W-1:0] DEC_RST = 4'h0;
    localparam logic [WIN_W-1:0] WIN_RST = 2'h0;

    // Status register field positions.
    localparam int ST_FULL_BIT   = 0;
    localparam int ST_GWIDTH_LSB = 8;
    localparam int ST_AWIDTH_LSB = 16;
    localparam int ST_LEVEL_LSB  = 24;

    // One raw input sample set from the sensor front end.
    typedef struct packed {
        logic [GYRO_AXES-1:0][GYRO_BASE_W-1:0]  gyro;
        logic [GYRO_AXES-1:0][ACCEL_BASE_W-1:0] accel;
    } iowg_raw_s;

    // One formatted output frame: upper word in [31:16], lower word in [15:0].
    typedef struct packed {
        logic [AXES-1:0][DATA_W-1:0] lane;
    } iowg_frame_s;

    // Register set occupancy.
    typedef enum logic [0:0] {
        SNAP_EMPTY = 1'b0,
        SNAP_FULL  = 1'b1
    } iowg_snap_e;

endpackage

// [src/iowg_width_growth.sv]
`timescale 1ns/10ps

// Behaviour
// R1: zero settings give 16-bit gyroscope samples.
// R2: decimation sums setting-plus-one successive samples.
// R3: each summation doubling adds one bit.
// R4: both window stages sum two-to-setting.
// R5: gyroscope lower words hold growth bits.
// R6: zero settings give 20-bit accelerometer samples.
// R7: accelerometer low bits left-justified in lower word.
// R8: burst read gives accelerometer upper words only; the code bursts the upper words of all six axes.
// R9: total growth sums decimation and both stages.
module iowg_width_growth (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sample_valid,
    input  wire iowg_pkg::iowg_raw_s sample_data,
    output logic                     sample_ready
);
    localparam int LW = $clog2(iowg_pkg::FIFO_DEPTH + 1);

    // Filter settings written by software.
    logic [iowg_pkg::DEC_W-1:0] dec_q, dec_d;
    logic [iowg_pkg::WIN_W-1:0] win_q, win_d;
    logic                       flush_q, flush_d;      // Restart pulse after a setting write.

    // Bus answer registers.
    logic [31:0]                rdata_q, rdata_d;
    logic                       ready_q, ready_d;
    logic                       err_q, err_d;

    // Input acceptance.
    logic                       accept_q, accept_d;

    // Register set holding the frame software reads.
    iowg_pkg::iowg_frame_s      snap_q, snap_d;
    iowg_pkg::iowg_snap_e       state_q, state_d;
    logic [2:0]                 burst_q, burst_d;      // Next burst axis.

    // Filter and queue wiring.
    logic [iowg_pkg::AXES-1:0]  fv;                    // Per-channel output strobes.
    logic signed [31:0]         fin  [iowg_pkg::AXES]; // Sign-extended inputs.
    logic signed [31:0]         fout [iowg_pkg::AXES]; // Filter sums.
    iowg_pkg::iowg_frame_s      push_frame;            // Formatted frame to queue.
    iowg_pkg::iowg_frame_s      head_frame;            // Oldest queued frame.
    logic                       head_valid;
    logic                       head_ready;
    logic [LW-1:0]              level;

    logic [5:0]                 gyro_w;                // Current gyroscope width.
    logic [5:0]                 accel_w;               // Current accelerometer width.

    logic                       setup;                 // APB setup phase.
    logic                       in_take;               // Input sample taken.

    assign prdata       = rdata_q;
    assign pready       = ready_q;
    assign pslverr      = err_q;

    assign sample_ready = accept_q;

    // R3: bits per doubling
    function automatic logic [5:0] log2_up(input logic [4:0] n);
        logic [5:0] b;
        b = '0;
        for (int i = 0; i < 5; i++) begin
            if ((5'd1 << i) < n) begin
                b = 6'(i + 1);
            end
        end

        return b;
    endfunction

    // Data width for a base width under the present settings.
    function automatic logic [5:0] width_of(input logic [5:0] base,
                                            input logic [iowg_pkg::DEC_W-1:0] d,
                                            input logic [iowg_pkg::WIN_W-1:0] w);

        // R9: sum of three growths
        return base + log2_up({1'b0, d} + 5'd1) + {3'b000, w, 1'b0};
    endfunction

    // Place a sum of the given width into upper and lower words.
    function automatic logic [31:0] justify(input logic signed [31:0] v,
                                            input logic [5:0] w);

        // R7: most significant bits first
        return v << (6'd32 - w);
    endfunction

    // APB byte offset of one axis register.
    function automatic logic [7:0] axis_ofs(input logic [7:0] base, input int a);
        return base + 8'(a * iowg_pkg::OFS_AXIS_STEP);
    endfunction

    assign gyro_w  = width_of(6'(iowg_pkg::GYRO_BASE_W), dec_q, win_q);
    assign accel_w = width_of(6'(iowg_pkg::ACCEL_BASE_W), dec_q, win_q);

    assign in_take = sample_valid && accept_q;
    assign setup   = psel && !penable;

    // Sign-extend the raw samples into the common channel width.
    always_comb begin
        for (int a = 0; a < iowg_pkg::GYRO_AXES; a++) begin
            fin[a] = 32'(signed'(sample_data.gyro[a]));

            fin[a + iowg_pkg::GYRO_AXES] = 32'(signed'(sample_data.accel[a]));
        end
    end

    // One filter per channel; all run in lock step from the same strobe.
    for (genvar g = 0; g < iowg_pkg::AXES; g++) begin : g_axis
        iowg_axis_filter u_filt (
            .pclk      (pclk),
            .presetn   (presetn),
            .flush     (flush_q),

            .in_valid  (in_take),
            .dec       (dec_q),
            .win       (win_q),
            .in_value  (fin[g]),

            .out_valid (fv[g]),
            .out_value (fout[g])
        );
    end

    // Format each filter sum at its present width.
    always_comb begin
        for (int a = 0; a < iowg_pkg::AXES; a++) begin
            if (a < iowg_pkg::GYRO_AXES) begin
                // R1: R5: gyroscope growth below
                push_frame.lane[a] = justify(fout[a], gyro_w);
            end else begin

                // R6: accelerometer base width
                push_frame.lane[a] = justify(fout[a], accel_w);
            end
        end
    end

    // Frame queue; its level throttles the input so frames are never dropped.
    iowg_fifo #(
        .WIDTH ($bits(iowg_pkg::iowg_frame_s)),
        .DEPTH (iowg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),

        .in_valid  (fv[0]),
        .in_ready  (),
        .in_data   (push_frame),

        .out_valid (head_valid),
        .out_ready (head_ready),
        .out_data  (head_frame),
        .level     (level)
    );

    assign head_ready = (state_q == iowg_pkg::SNAP_EMPTY);

    // Input acceptance leaves room for samples still in flight.
    always_comb begin
        // A settings write stalls input in its access cycle and the next, so no sample is taken in the flush cycle.
        accept_d = (level <= LW'(iowg_pkg::ACCEPT_LEVEL)) && !flush_d
                   && !flush_q;
    end

    // Register set loading, software release and the burst walk.
    always_comb begin
        state_d = state_q;
        snap_d  = snap_q;
        burst_d = burst_q;
        case (state_q)

            iowg_pkg::SNAP_EMPTY: begin
                // Take the oldest frame as soon as one waits.
                if (head_valid) begin
                    snap_d  = head_frame;
                    burst_d = '0;
                    state_d = iowg_pkg::SNAP_FULL;
                end
            end

            iowg_pkg::SNAP_FULL: begin
                // Software writes one to the full bit to take the next frame.
                if (setup && pwrite && paddr == iowg_pkg::OFS_STATUS
                        && pwdata[iowg_pkg::ST_FULL_BIT]) begin
                    state_d = iowg_pkg::SNAP_EMPTY;
                end
            end
            default: begin
                state_d = iowg_pkg::SNAP_EMPTY;
            end
        endcase

        // R8: upper words only
        if (setup && !pwrite && paddr == iowg_pkg::OFS_BURST) begin
            burst_d = (burst_q == 3'(iowg_pkg::AXES - 1)) ? '0 : burst_q + 1'b1;
        end
    end

    // Bus decode: settings writes, read mux and error answer.
    always_comb begin
        dec_d   = dec_q;
        win_d   = win_q;
        flush_d = 1'b0;
        rdata_d = rdata_q;
        ready_d = setup;
        err_d   = setup;

        if (setup) begin
            rdata_d = '0;
            case (paddr)
                iowg_pkg::OFS_DEC: begin
                    err_d   = 1'b0;
                    rdata_d = 32'(dec_q);
                    if (pwrite) begin
                        dec_d   = pwdata[iowg_pkg::DEC_W-1:0];
                        flush_d = 1'b1;
                    end
                end

                iowg_pkg::OFS_WIN: begin
                    err_d   = 1'b0;
                    rdata_d = 32'(win_q);
                    if (pwrite) begin
                        win_d   = pwdata[iowg_pkg::WIN_W-1:0];
                        flush_d = 1'b1;
                    end
                end

                iowg_pkg::OFS_STATUS: begin
                    err_d = 1'b0;
                    rdata_d[iowg_pkg::ST_FULL_BIT] = (state_q == iowg_pkg::SNAP_FULL);
                    rdata_d[iowg_pkg::ST_GWIDTH_LSB +: 6] = gyro_w;
                    rdata_d[iowg_pkg::ST_AWIDTH_LSB +: 6] = accel_w;

                    rdata_d[iowg_pkg::ST_LEVEL_LSB +: LW] = level;
                end

                iowg_pkg::OFS_BURST: begin
                    err_d   = pwrite;
                    rdata_d = {16'h0000, snap_q.lane[burst_q][31:16]};
                end
                default: begin
                    // Per-axis upper and lower words are read-only.
                    for (int a = 0; a < iowg_pkg::AXES; a++) begin
                        if (paddr == axis_ofs(iowg_pkg::OFS_UPPER_BASE, a)) begin
                            err_d   = pwrite;
                            rdata_d = {16'h0000, snap_q.lane[a][31:16]};
                        end

                        if (paddr == axis_ofs(iowg_pkg::OFS_LOWER_BASE, a)) begin
                            err_d   = pwrite;
                            rdata_d = {16'h0000, snap_q.lane[a][15:0]};
                        end
                    end
                end
            endcase
        end
    end

    // All control registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_q    <= iowg_pkg::DEC_RST;
            win_q    <= iowg_pkg::WIN_RST;
            flush_q  <= 1'b0;

            rdata_q  <= '0;
            ready_q  <= 1'b0;
            err_q    <= 1'b0;
            accept_q <= 1'b0;

            snap_q   <= '0;
            state_q  <= iowg_pkg::SNAP_EMPTY;
            burst_q  <= '0;
        end else begin

            dec_q    <= dec_d;
            win_q    <= win_d;
            flush_q  <= flush_d;

            rdata_q  <= rdata_d;
            ready_q  <= ready_d;
            err_q    <= err_d;
            accept_q <= accept_d;

            snap_q   <= snap_d;
            state_q  <= state_d;
            burst_q  <= burst_d;
        end
    end
endmodule
